// *** icd_pkg.sv ***
// constants, carriers and decode helpers for the debug probe control
// assumes one 125 MHz core clock and a zero-wait APB register port
package icd_pkg;

  // ==========================================================
  // timing
  localparam int CLOCK_MHZ = 125;
  localparam int HALT_DBG_CLK_MAX_MHZ = 40;
  localparam int TRACE_MAX_MHZ = 100;
  localparam int TRACE_DEPTH_DEF = 1048576;
  localparam int TRACE_CNT_W = 21;
  localparam int BREAK_DELAY_INSNS = 3;
  localparam int DIV_CNT_W = 4;

  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TRIG1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIG2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BUSBRK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_AREA_TIME = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_SWITCH = 8'h20;
  localparam int CTRL_CAP_LAST = 0;
  localparam int CTRL_AREA = 1;
  localparam int CTRL_PHYS = 2;
  localparam int CTRL_BUSBRK_EN = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int CMD_GO = 0;
  localparam int CMD_BREAK = 1;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic programmer_enable_switch;
    logic ratio_switch_a;
    logic ratio_switch_b;
    logic trace_switch_a;
    logic trace_switch_b;
    logic diagnostics_skip_switch;
    logic verify_select_switch;
    logic io_level_switch;
  } icd_switch_s;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
    logic psel;
    logic penable;
  } icd_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } icd_apb_rsp_s;

  typedef struct packed {
    logic insn_valid;
    logic [31:0] pc;
    logic bus_valid;
    logic [31:0] bus_log;
    logic [31:0] bus_phys;
  } icd_target_s;

  typedef enum logic [1:0] {RUN_HALTED, RUN_GOING, RUN_BRK_PEND} icd_run_e;
  typedef enum logic {AREA_WAIT1, AREA_INSIDE} icd_area_e;

  typedef struct packed {
    icd_switch_s sw;
    logic sw_taken;
    icd_run_e run;
    logic [3:0] brk_cnt;
    logic [3:0] ctrl;
    logic [31:0] trig1;
    logic [31:0] trig2;
    logic [31:0] busbrk;
    logic [TRACE_CNT_W-1:0] cnt;
    logic full;
    icd_area_e area;
    logic [31:0] area_time;
    logic trig_hit;
    logic [31:0] prdata;
    logic [31:0] bus_addr;
    logic trace_wr;
    logic push_q;
    logic prog_start;
    logic probe_rst;
  } icd_state_s;

  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
  } icd_div_s;

  // ==========================================================
  // halted debug clock divisor from the two ratio switches
  function automatic logic [3:0] icd_ratio_div(input logic a,
                                               input logic b);
    case ({a, b})
      2'b00: icd_ratio_div = 4'h4;
      2'b01: icd_ratio_div = 4'h2;
      2'b10: icd_ratio_div = 4'h1;
      default: icd_ratio_div = 4'h8;
    endcase
  endfunction : icd_ratio_div

endpackage : icd_pkg

// *** icd_clk_div.sv ***
// debug clock enable divider
// assumes divisor is 1, 2, 4 or 8 and is steady between frames
`timescale 1ns/1ns
module icd_clk_div #(
  parameter int CNT_W = icd_pkg::DIV_CNT_W
) (
  // clock and reset
  input logic clock,
  input logic reset,
  // rate control
  input logic full_rate,
  input logic [3:0] divisor,
  // enable out
  output logic tick
);
  import icd_pkg::*;

  generate
    if (CNT_W < 4) begin : g_bad_width
      $error("divider counter too narrow");
    end
  endgenerate

  icd_div_s state_q;
  icd_div_s state_d;

  // >= guards against a divisor that shrinks mid-count
  assign tick = full_rate ||
                (state_q.cnt >= CNT_W'(divisor) - CNT_W'(1));

  always_comb begin
    state_d = state_q;
    if (tick) begin
      state_d.cnt = '0;
    end else begin
      state_d.cnt = state_q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule : icd_clk_div

// *** icd_debug_ctrl.sv ***
// mode, trace capture and monitor pin control of the debug probe
// assumes all inputs synchronous to clock; APB answers with no wait
//
// What this block does
// - programmer mode only with enable switch; verify switch picks verify
// - halted debug clock is core clock over 4, 2, 1 or 8
// - running debug clock equals core clock; trace over 100 MHz is only flagged in status
// - trace switches pick pc/bus trace; both closed is refused
// - diagnostics switch open runs connection test at start
// - level switch open means high io level, closed low
// - normal trace keeps first window after go or last before break
// - area trace records only between trigger one and two
// - trigger two before trigger one never opens an area
// - bus trace and bus break use logical or physical address
// - area mode totals cycles spent inside the area
// - trace full output rises when trace memory fills
// - execution status output low while running, high on break
// - trigger output high on trigger hit and while halted
// - with monitor jumper, zero target supply cuts target power
// - push switch resets probe, or starts programming in that mode
// - trace full stays lit until the next go
// - low external break while running halts after some insns
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module icd_debug_ctrl #(
  parameter int TRACE_DEPTH = icd_pkg::TRACE_DEPTH_DEF
) (
  // clock and reset
  input logic clock,
  input logic reset,
  // register bus
  input icd_pkg::icd_apb_req_s apb_req,
  output icd_pkg::icd_apb_rsp_s apb_rsp,
  // switches and jumper
  input icd_pkg::icd_switch_s switches,
  input logic push_switch,
  input logic monitor_on_jumper,
  input logic target_vcc_zero,
  // target activity
  input icd_pkg::icd_target_s target,
  input logic external_break_in,
  // link and modes
  output logic debug_clock_en,
  output logic io_level_low,
  output logic conn_test_en,
  output logic prog_mode_en,
  output logic prog_verify,
  output logic prog_start,
  output logic probe_reset,
  output logic target_power_en,
  // trace store
  output logic trace_write,
  output logic [31:0] trace_bus_addr,
  // monitor pins
  output logic trace_full_out,
  output logic executing_status_out,
  output logic trace_trigger_out
);
  import icd_pkg::*;

  localparam logic [TRACE_CNT_W-1:0] DEPTH_C =
    TRACE_CNT_W'(TRACE_DEPTH);
  localparam logic [3:0] BRK_LAST = 4'(BREAK_DELAY_INSNS - 1);
  localparam logic TRACE_OVER = (CLOCK_MHZ > TRACE_MAX_MHZ);

  generate
    if (TRACE_DEPTH < 2 || TRACE_DEPTH > TRACE_DEPTH_DEF) begin : g_bad
      $error("trace depth out of range");
    end
    if (BREAK_DELAY_INSNS < 1 || BREAK_DELAY_INSNS > 16) begin : g_bd
      $error("break delay out of range");
    end
  endgenerate

  // ==========================================================
  // decode
  icd_state_s q;
  icd_state_s d;
  logic [3:0] ratio;
  logic running;
  logic halted;
  logic pc_en;
  logic bus_en;
  logic trace_bad;
  logic trace_on;
  logic area_mode;
  logic wr_acc;
  logic rd_setup;
  logic go_cmd;
  logic brk_cmd;
  logic hit1;
  logic hit2;
  logic busbrk_hit;
  logic cap;
  logic halted_over;
  logic mapped;
  logic [31:0] bus_sel;
  logic [31:0] rdata;

  assign running = (q.run != RUN_HALTED);
  assign halted = !running;
  assign ratio = icd_ratio_div(q.sw.ratio_switch_a,
                               q.sw.ratio_switch_b);
  // b closed kills pc trace; a adds bus trace; both is illegal
  assign trace_bad = q.sw.trace_switch_a &&
                     q.sw.trace_switch_b;
  assign pc_en = !q.sw.trace_switch_b;
  assign bus_en = q.sw.trace_switch_a &&
                  !q.sw.trace_switch_b;
  assign trace_on = pc_en || bus_en;
  assign area_mode = q.ctrl[CTRL_AREA];
  // status only: the user owns keeping the halted rate legal
  assign halted_over =
    (CLOCK_MHZ > HALT_DBG_CLK_MAX_MHZ * int'(ratio));

  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_setup = apb_req.psel && !apb_req.penable &&
                    !apb_req.pwrite;
  assign go_cmd = wr_acc && (apb_req.paddr == OFS_CMD) &&
                  apb_req.pwdata[CMD_GO];
  assign brk_cmd = wr_acc && (apb_req.paddr == OFS_CMD) &&
                   apb_req.pwdata[CMD_BREAK];

  assign hit1 = target.insn_valid && (target.pc == q.trig1);
  assign hit2 = target.insn_valid && (target.pc == q.trig2);
  assign bus_sel = q.ctrl[CTRL_PHYS] ? target.bus_phys
                                     : target.bus_log;
  assign busbrk_hit = target.bus_valid && q.ctrl[CTRL_BUSBRK_EN] &&
                      (bus_sel == q.busbrk);

  // trace memory takes a cycle only while running and, in area
  // mode, only inside the opened area
  assign cap = running && trace_on &&
               (!area_mode || q.area == AREA_INSIDE);

  // ==========================================================
  // register read mux
  always_comb begin
    mapped = 1'b1;
    rdata = '0;
    case (apb_req.paddr)
      OFS_CTRL: rdata = {28'h0000000, q.ctrl};
      OFS_TRIG1: rdata = q.trig1;
      OFS_TRIG2: rdata = q.trig2;
      OFS_BUSBRK: rdata = q.busbrk;
      OFS_CMD: rdata = '0;
      OFS_STATUS: rdata = {22'h000000, bus_en, pc_en, TRACE_OVER,
                           halted_over, prog_verify, prog_mode_en,
                           trace_bad, q.area == AREA_INSIDE,
                           q.full, running};
      OFS_COUNT: rdata = {{(32-TRACE_CNT_W){1'b0}}, q.cnt};
      OFS_AREA_TIME: rdata = q.area_time;
      OFS_SWITCH: rdata = {24'h000000, q.sw};
      default: mapped = 1'b0;
    endcase
  end

  assign apb_rsp.prdata = q.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.trig_hit = 1'b0;
    d.trace_wr = 1'b0;
    d.prog_start = 1'b0;
    d.probe_rst = 1'b0;
    d.push_q = push_switch;

    // switches are a strap: caught once after reset, then frozen
    if (!q.sw_taken) begin
      d.sw = switches;
      d.sw_taken = 1'b1;
    end

    if (wr_acc) begin
      case (apb_req.paddr)
        OFS_CTRL: d.ctrl = apb_req.pwdata[3:0];
        OFS_TRIG1: d.trig1 = apb_req.pwdata;
        OFS_TRIG2: d.trig2 = apb_req.pwdata;
        OFS_BUSBRK: d.busbrk = apb_req.pwdata;
        default: ;
      endcase
    end
    if (rd_setup) begin
      d.prdata = rdata;
    end

    // run control
    case (q.run)
      RUN_HALTED: begin
        if (go_cmd) begin
          d.run = RUN_GOING;
          d.cnt = '0;
          d.full = 1'b0;
          d.area = AREA_WAIT1;
          d.area_time = '0;
        end
      end
      RUN_GOING: begin
        if (!external_break_in) begin
          d.run = RUN_BRK_PEND;
          d.brk_cnt = '0;
        end
      end
      RUN_BRK_PEND: begin
        // the target retires a few more instructions first
        if (target.insn_valid) begin
          if (q.brk_cnt == BRK_LAST) begin
            d.run = RUN_HALTED;
          end else begin
            d.brk_cnt = q.brk_cnt + 4'h1;
          end
        end
      end
      default: d.run = RUN_HALTED;
    endcase
    if (running && (brk_cmd || busbrk_hit)) begin
      d.run = RUN_HALTED;
    end

    // area triggers: one must come first, then two
    if (area_mode && running) begin
      case (q.area)
        AREA_WAIT1: begin
          if (hit1) begin
            d.area = AREA_INSIDE;
            d.trig_hit = 1'b1;
          end
        end
        AREA_INSIDE: begin
          if (hit2) begin
            d.area = AREA_WAIT1;
            d.trig_hit = 1'b1;
          end
        end
        default: d.area = AREA_WAIT1;
      endcase
    end
    if (running && q.area == AREA_INSIDE) begin
      d.area_time = q.area_time + 32'h1;
    end

    // capture window: the first DEPTH cycles fill and stop; in
    // last-window mode the store keeps wrapping until the break
    if (cap) begin
      if (!q.full) begin
        d.trace_wr = 1'b1;
        d.cnt = q.cnt + TRACE_CNT_W'(1);
        if (q.cnt == DEPTH_C - TRACE_CNT_W'(1)) begin
          d.full = 1'b1;
        end
      end else if (q.ctrl[CTRL_CAP_LAST] && !area_mode) begin
        d.trace_wr = 1'b1;
      end
    end
    if (target.bus_valid && bus_en) begin
      d.bus_addr = bus_sel;
    end

    // one push switch, two jobs
    if (push_switch && !q.push_q) begin
      if (prog_mode_en) begin
        d.prog_start = 1'b1;
      end else begin
        d.probe_rst = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // debug clock: full rate while running, divided while halted
  icd_clk_div u_div (
    .clock(clock),
    .reset(reset),
    .full_rate(running),
    .divisor(ratio),
    .tick(debug_clock_en)
  );

  // ==========================================================
  // outputs
  assign prog_mode_en = q.sw.programmer_enable_switch;
  assign prog_verify = q.sw.programmer_enable_switch &&
                       q.sw.verify_select_switch;
  assign conn_test_en = !q.sw.diagnostics_skip_switch;
  assign io_level_low = q.sw.io_level_switch;
  assign target_power_en = !(monitor_on_jumper &&
                             target_vcc_zero);
  assign prog_start = q.prog_start;
  assign probe_reset = q.probe_rst;
  assign trace_write = q.trace_wr;
  assign trace_bus_addr = q.bus_addr;
  assign trace_full_out = q.full;
  assign executing_status_out = halted;
  assign trace_trigger_out = q.trig_hit || halted;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_brk_req;
    q.run == RUN_GOING && !external_break_in && !brk_cmd &&
    !busbrk_hit;
  endsequence

  sequence s_reverse_hit;
    area_mode && running && q.area == AREA_WAIT1 && hit2 && !hit1;
  endsequence

  a_prog_verify: assert property (
    prog_verify |-> prog_mode_en && q.sw.verify_select_switch)
    else $error("verify mode without programmer mode");

  a_halt_ratio: assert property (
    halted && debug_clock_en && $past(halted) && ratio != 4'h1
    |-> !$past(debug_clock_en))
    else $error("halted debug clock not divided");

  a_run_rate: assert property (
    running |-> debug_clock_en)
    else $error("running debug clock not at core rate");

  a_trace_illegal: assert property (
    trace_bad |=> !trace_write)
    else $error("trace written under illegal switch setting");

  a_area_outside: assert property (
    area_mode && q.area != AREA_INSIDE |=> !trace_write)
    else $error("area trace wrote outside the area");

  a_reverse_order: assert property (
    s_reverse_hit |=> q.area == AREA_WAIT1 && !q.trig_hit)
    else $error("reverse trigger order opened an area");

  a_area_time: assert property (
    running && q.area == AREA_INSIDE
    |=> q.area_time == $past(q.area_time) + 32'h1)
    else $error("area time not counting");

  a_fill_full: assert property (
    cap && !q.full && q.cnt == DEPTH_C - TRACE_CNT_W'(1)
    |=> trace_full_out)
    else $error("trace full missed at fill");

  a_exec_status: assert property (
    $fell(executing_status_out) |-> $past(go_cmd))
    else $error("execution status fell without go");

  a_trg_hit: assert property (
    area_mode && running && q.area == AREA_WAIT1 && hit1
    |=> trace_trigger_out)
    else $error("trigger output missed trigger one");

  a_power_cut: assert property (
    monitor_on_jumper && target_vcc_zero |-> !target_power_en)
    else $error("target power kept with zero supply");

  a_push_prog: assert property (
    push_switch && !q.push_q && prog_mode_en
    |=> prog_start && !probe_reset)
    else $error("push in programmer mode did not start");

  a_full_sticky: assert property (
    trace_full_out && !go_cmd |=> trace_full_out)
    else $error("trace full dropped without go");

  a_ext_break: assert property (
    s_brk_req |=> q.run == RUN_BRK_PEND && debug_clock_en)
    else $error("external break not taken");

  a_switch_hold: assert property (
    q.sw_taken |=> $stable(q.sw))
    else $error("switch settings changed after sampling");

endmodule : icd_debug_ctrl

// *** icd_target_model.sv ***
// target debug unit model: runs a straight-line program from 0x100
// assumes running follows the probe's run state and slow halves the rate
`timescale 1ns/1ns
module icd_target_model (
  // clock and reset
  input logic clock,
  input logic reset,
  // control from the bench
  input logic running,
  input logic slow,
  // target activity
  output icd_pkg::icd_target_s target
);
  import icd_pkg::*;
  logic [31:0] pc_q;
  logic ph_q;
  logic v;

  // ==========================================================
  // program counter
  always_ff @(posedge clock) begin
    if (reset || !running) begin
      pc_q <= 32'h00000100;
      ph_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      if (!slow || ph_q) begin
        pc_q <= pc_q + 32'h4;
      end
    end
  end

  // ==========================================================
  // activity; idle fields show the inverse so no stale address matches
  // keeps executing after a break request so the delay can run out
  assign v = running && (!slow || ph_q);
  always_comb begin
    target.insn_valid = v;
    target.bus_valid = v;
    target.pc = v ? pc_q : ~pc_q;
    target.bus_log = v ? pc_q : ~pc_q;
    target.bus_phys = v ? {4'h8, pc_q[27:0]} : ~pc_q;
  end
endmodule : icd_target_model

// *** tb_in_circuit_debug_control.sv ***
// self-checking bench for the debug probe control block
// assumes the target model on the far side and a zero-wait APB port
`timescale 1ns/1ns
module tb_in_circuit_debug_control;
  import icd_pkg::*;
  localparam int DEPTH = 16;
  logic clock = 1'b0;
  logic reset = 1'b1;
  icd_apb_req_s req = '0;
  icd_apb_rsp_s rsp;
  icd_switch_s sw = '0;
  logic push = 1'b0;
  logic jmp = 1'b0;
  logic vz = 1'b0;
  logic ebrk_n = 1'b1;
  logic slow = 1'b0;
  icd_target_s tgt;
  logic dbg_clk_en, lvl_low, conn, pmode, pver, pstart, prst, pwr;
  logic tw, tfull, halted, trig, trg_p;
  logic [31:0] baddr, rd;
  logic err;
  int num_errors = 0;
  int n_checks = 0;
  int n_tw = 0, n_trg = 0, n_ps = 0, n_pr = 0, n_dc = 0;
  int c, c2, dv;
  logic [7:0] s;
  // prog, ratio a/b, trace a/b, diag, verify, level; bus trace set last
  logic [7:0] tbl [4] = '{8'h00, 8'hAC, 8'hDA, 8'h73};

  always #4 clock = ~clock;

  icd_debug_ctrl #(.TRACE_DEPTH(DEPTH)) uut (.clock(clock), .reset(reset),
    .apb_req(req), .apb_rsp(rsp), .switches(sw), .push_switch(push),
    .monitor_on_jumper(jmp), .target_vcc_zero(vz), .target(tgt),
    .external_break_in(ebrk_n), .debug_clock_en(dbg_clk_en),
    .io_level_low(lvl_low), .conn_test_en(conn), .prog_mode_en(pmode),
    .prog_verify(pver), .prog_start(pstart), .probe_reset(prst),
    .target_power_en(pwr), .trace_write(tw), .trace_bus_addr(baddr),
    .trace_full_out(tfull), .executing_status_out(halted),
    .trace_trigger_out(trig));

  icd_target_model tm (.clock(clock), .reset(reset), .running(!halted),
    .slow(slow), .target(tgt));

  // ==========================================================
  // pulse counters
  always @(posedge clock) begin
    n_tw <= n_tw + int'(tw === 1'b1);
    n_ps <= n_ps + int'(pstart === 1'b1);
    n_pr <= n_pr + int'(prst === 1'b1);
    n_dc <= n_dc + int'(dbg_clk_en === 1'b1);
    n_trg <= n_trg + int'(halted === 1'b0 && trig === 1'b1 && !trg_p);
    trg_p <= trig;
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_sim;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int k;
    @(posedge clock);
    req <= '{a, w, d, 1'b1, 1'b0};
    @(posedge clock);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (rsp.pready !== 1'b1 && k < 40);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (k >= 40) begin
      chk("apb wait", 0, 1);
      end_sim;
    end
  endtask : apb

  task automatic wait_st(input logic v, input int b);
    int k;
    k = 0;
    while (halted !== v && k < b) begin
      @(posedge clock);
      k++;
    end
    if (halted !== v) begin
      chk("run state wait", v, halted);
      end_sim;
    end
  endtask : wait_st

  task automatic go(input logic [31:0] ctrl);
    apb(OFS_CTRL, 1'b1, ctrl);
    apb(OFS_CMD, 1'b1, 32'h1);
    wait_st(1'b0, 10);
  endtask : go

  task automatic brk;
    apb(OFS_CMD, 1'b1, 32'h2);
    wait_st(1'b1, 10);
    cyc(3);
  endtask : brk

  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      s = tbl[i];
      sw <= s;
      reset <= 1'b1;
      jmp <= i[0];
      vz <= i[1];
      cyc(2);
      reset <= 1'b0;
      cyc(3);
      sw <= ~s;
      cyc(2);
      chk("halted", 1, halted);
      chk("trigger halted", 1, trig);
      chk("power", !(i[0] && i[1]), pwr);
      apb(OFS_SWITCH, 1'b0, 32'h0);
      chk("switches", {24'h0, s}, rd);
      chk("prog mode", s[7], pmode);
      chk("verify", s[7] & s[1], pver);
      chk("conn test", !s[2], conn);
      chk("io level", s[0], lvl_low);
      case (s[6:5])
        2'b00: dv = 4;
        2'b01: dv = 2;
        2'b10: dv = 1;
        default: dv = 8;
      endcase
      c = n_dc;
      cyc(32);
      chk("halted debug clock", 32 / dv, n_dc - c);
      apb(OFS_STATUS, 1'b0, 32'h0);
      chk("illegal", s[4] & s[3], rd[3]);
      chk("pc trace", !s[3], rd[8]);
      chk("bus trace", s[4] & !s[3], rd[9]);
      chk("debug clock limit", dv < 4, rd[6]);
      c = n_ps;
      c2 = n_pr;
      push <= 1'b1;
      cyc(3);
      push <= 1'b0;
      cyc(3);
      chk("prog start", s[7], n_ps - c);
      chk("probe reset", !s[7], n_pr - c2);
    end
    jmp <= 1'b0;
    vz <= 1'b0;
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped data", 0, rd);
    chk("unmapped err", 1, err);
    // first window, break by command
    c = n_tw;
    go(32'h0);
    cyc(2);
    chk("trigger run", 0, trig);
    c2 = n_dc;
    cyc(20);
    chk("running debug clock", 20, n_dc - c2);
    cyc(20);
    c2 = n_tw;
    cyc(8);
    chk("first window", 0, n_tw - c2);
    chk("full", 1, tfull);
    brk;
    chk("full held", 1, tfull);
    chk("first writes", DEPTH, n_tw - c);
    apb(OFS_COUNT, 1'b0, 32'h0);
    chk("count", DEPTH, rd);
    // last window, logical bus break armed, external break, slow target
    apb(OFS_BUSBRK, 1'b1, 32'h80000140);
    slow <= 1'b1;
    go(32'h9);
    cyc(2);
    chk("full cleared", 0, tfull);
    cyc(40);
    c2 = n_tw;
    cyc(8);
    chk("last window", 8, n_tw - c2);
    chk("logical addr", 0, baddr[31:28]);
    ebrk_n <= 1'b0;
    cyc(2);
    chk("break delay", 0, halted);
    wait_st(1'b1, 20);
    ebrk_n <= 1'b1;
    slow <= 1'b0;
    chk("full last", 1, tfull);
    // physical bus break halts on its own
    go(32'hC);
    wait_st(1'b1, 60);
    chk("physical addr", 8, baddr[31:28]);
    // area between triggers in order
    apb(OFS_TRIG1, 1'b1, 32'h110);
    apb(OFS_TRIG2, 1'b1, 32'h120);
    c = n_tw;
    c2 = n_trg;
    go(32'h2);
    cyc(40);
    brk;
    chk("trigger pulses", 2, n_trg - c2);
    chk("area writes", 1, (n_tw - c) >= 3 && (n_tw - c) <= 5);
    apb(OFS_AREA_TIME, 1'b0, 32'h0);
    chk("area time", 1, rd >= 3 && rd <= 5);
    // second trigger alone never opens the area
    apb(OFS_TRIG1, 1'b1, 32'hFFF0);
    apb(OFS_TRIG2, 1'b1, 32'h110);
    c = n_tw;
    c2 = n_trg;
    go(32'h2);
    cyc(40);
    brk;
    chk("reverse pulses", 0, n_trg - c2);
    chk("reverse writes", 0, n_tw - c);
    apb(OFS_AREA_TIME, 1'b0, 32'h0);
    chk("reverse time", 0, rd);
    end_sim;
  end
endmodule : tb_in_circuit_debug_control
